// ===== dv/ofm_top_test.sv
`timescale 1ns/1ns
`include "ofm_regs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end

module ofm_top_test;
  import ofm_pkg::*;
  logic CORE_CLK, NRST, AUX_CLK_IN, SUB_CLK_IN, OSC_CLK_IN;
  ofm_bus_req_t BUS_REQ;
  logic [15:0] BUS_RDATA, d;
  logic OSC_ENABLE, OSC_NOM_SEL, OSC_RANGE_4MHZ, SAMPLE_TICK, STEP_TICK, MEAS_BUSY, MEAS_DONE;
  logic [3:0] OSC_TRIM;
  int n_fail, n_tests, cycles, per, qq, ph, st, rem, cnt, i;
  int n_aux, n_sub, n_osc, n_samp, n_step;
  bit quiet;

  ofm_top u_ofm_top (.CORE_CLK(CORE_CLK), .NRST(NRST), .BUS_REQ(BUS_REQ),
    .BUS_RDATA(BUS_RDATA), .AUX_CLK_IN(AUX_CLK_IN), .SUB_CLK_IN(SUB_CLK_IN),
    .OSC_CLK_IN(OSC_CLK_IN), .OSC_ENABLE(OSC_ENABLE), .OSC_NOM_SEL(OSC_NOM_SEL),
    .OSC_RANGE_4MHZ(OSC_RANGE_4MHZ), .OSC_TRIM(OSC_TRIM), .SAMPLE_TICK(SAMPLE_TICK),
    .STEP_TICK(STEP_TICK), .MEAS_BUSY(MEAS_BUSY), .MEAS_DONE(MEAS_DONE));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One cycle of sources plus model; no osc or sub edge near a rising aux edge,
  // so the expected count never hangs on a same-cycle tie
  task automatic cyc();
    logic a, s, o;
    @(posedge CORE_CLK);
    ph = (ph + 1) % per;
    a = ph < per / 2;
    s = !quiet && ph > 2 && ph < per - 3 && (ph % 4) < 2;
    o = !quiet && ph > 2 && ph < per - 3 && (ph % qq) == 0;
    if (a && !AUX_CLK_IN) begin
      n_aux++;
      if (st == 1) st = 2;
      else if (st == 2) begin rem--; if (rem == 0) st = 3; end
    end
    if (s && !SUB_CLK_IN) n_sub++;
    if (o && !OSC_CLK_IN) begin n_osc++; if (st == 2 && cnt < 255) cnt++; end
    AUX_CLK_IN <= a;
    SUB_CLK_IN <= s;
    OSC_CLK_IN <= o;
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] w);
    cyc(); BUS_REQ <= '{a, w, 1'b1, 1'b0};
    cyc(); BUS_REQ <= '0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    cyc(); BUS_REQ <= '{a, 16'h0000, 1'b0, 1'b1};
    cyc(); BUS_REQ <= '0;
    `CHK(BUS_RDATA, e)
  endtask

  task automatic to_mid();
    repeat (4) cyc();
    while (ph != per / 2) cyc();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic meas(input int p, input int q, input bit nom);
    logic [3:0] tr;
    bit chk;
    per = p; qq = q; chk = 0; tr = 4'($urandom_range(15));
    to_mid();
    wr(`OFM_CTL5_OFS, {6'h00, 2'($urandom_range(3)), tr, 1'b0, nom, 2'b11});
    st = 1; cnt = 0; rem = nom ? 4 : 1;
    `CHK(OSC_TRIM, tr)
    for (int t = 0; t < 6 * per && MEAS_DONE !== 1'b1; t++) begin
      if (st == 2 && !chk && ph == per / 2) begin
        `CHK(MEAS_BUSY, 1'b1)
        rd(`OFM_CNT_OFS, 16'h0001);
        chk = 1;
      end
      else cyc();
    end
    `CHK(st == 3, 1'b1)
    rd(`OFM_CNT_OFS, cnt[15:0]);
    repeat (20) cyc();
    rd(`OFM_CNT_OFS, cnt[15:0]);
    rd(`OFM_STAT_OFS, 16'h0002);
  endtask

  task automatic ticks(input int s);
    int a0, x0, p0, q0;
    wr(`OFM_CTL5_OFS, {6'h00, s[1:0], 8'h01});
    quiet = 1; to_mid();
    a0 = n_aux; x0 = (s == 1) ? n_sub : (s == 2) ? n_osc : n_aux;
    p0 = n_samp; q0 = n_step;
    quiet = 0; repeat (3 * per) cyc();
    quiet = 1; to_mid();
    `CHK(n_samp - p0, n_aux - a0)
    `CHK(n_step - q0, ((s == 1) ? n_sub : (s == 2) ? n_osc : n_aux) - x0)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge CORE_CLK)
  begin
    cycles++;
    if (SAMPLE_TICK === 1'b1) n_samp++;
    if (STEP_TICK === 1'b1) n_step++;
    if (cycles == 20000) begin n_fail++; results(); end
  end

  initial
  begin
    CORE_CLK = 0;
    forever #50 CORE_CLK = ~CORE_CLK;
  end

  initial
  begin
    NRST = 0; BUS_REQ = '0; AUX_CLK_IN = 0; SUB_CLK_IN = 0; OSC_CLK_IN = 0;
    per = 64; qq = 3; ph = 0; st = 0; quiet = 0;
    void'($urandom(32'h37afc665));
    repeat (6) @(posedge CORE_CLK);
    NRST <= 1'b1;
    #1;
    `CHK(OSC_RANGE_4MHZ, 1'b1)
    rd(`OFM_CTL5_OFS, `OFM_CTL5_RST);
    rd(4'h7, 16'h0000);
    rd(`OFM_STAT_OFS, 16'h0000);
    // Every trim code, so both ends of the range reach the pin
    for (i = 0; i < 16; i++) begin
      d = 16'($urandom) & 16'h0375;
      d[7:4] = i[3:0];
      wr(`OFM_CTL5_OFS, d);
      rd(`OFM_CTL5_OFS, d);
      `CHK(OSC_NOM_SEL, d[2])
      `CHK(OSC_RANGE_4MHZ, !d[2])
      `CHK(OSC_TRIM, d[7:4])
      `CHK(OSC_ENABLE, d[0])
    end
    // Repeated measure runs with fresh trim codes, as periodic recalibration would
    for (i = 0; i < 6; i++) meas(64, $urandom_range(6, 3), i[0]);
    meas(200, 3, 1'b1);
    wr(`OFM_CTL5_OFS, 16'h0003);
    repeat (4) cyc();
    wr(`OFM_CTL5_OFS, 16'h0000);
    rd(`OFM_STAT_OFS, 16'h0000);
    `CHK(MEAS_BUSY, 1'b0)
    for (i = 0; i < 4; i++) ticks(i);
    results();
  end
endmodule

// ===== hdl/ofm_top.sv
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "ofm_regs.svh"


module ofm_top (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // Register port
  input wire ofm_pkg::ofm_bus_req_t BUS_REQ,
  output logic [15:0] BUS_RDATA,
  // Clock sources, sampled on CORE_CLK
  input wire logic AUX_CLK_IN,
  input wire logic SUB_CLK_IN,
  input wire logic OSC_CLK_IN,
  // Oscillator control
  output logic OSC_ENABLE,
  output logic OSC_NOM_SEL,
  output logic OSC_RANGE_4MHZ,
  output logic [3:0] OSC_TRIM,
  // Timing ticks to the sequencer
  output logic SAMPLE_TICK,
  output logic STEP_TICK,
  // Measurement state
  output logic MEAS_BUSY,
  output logic MEAS_DONE
);
  import ofm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on sampled clock inputs

  logic aux_q_reg;
  logic sub_q_reg;
  logic osc_q_reg;
  logic aux_rise;
  logic sub_rise;
  logic osc_rise;

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      aux_q_reg <= 1'b0;
      sub_q_reg <= 1'b0;
      osc_q_reg <= 1'b0;
    end
    else
    begin
      aux_q_reg <= AUX_CLK_IN;
      sub_q_reg <= SUB_CLK_IN;
      osc_q_reg <= OSC_CLK_IN;
    end
  end

  // Oscillator must stay below half CORE_CLK or edges are lost
  assign aux_rise = AUX_CLK_IN & ~aux_q_reg;
  assign sub_rise = SUB_CLK_IN & ~sub_q_reg;
  assign osc_rise = OSC_CLK_IN & ~osc_q_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  ofm_ctl_t ctl_reg;
  logic ctl_wr;
  logic cnt_rd;
  logic arm_req;

  assign ctl_wr = BUS_REQ.wr && (BUS_REQ.addr == `OFM_CTL5_OFS);
  assign cnt_rd = BUS_REQ.rd && (BUS_REQ.addr == `OFM_CNT_OFS);
  assign arm_req = ctl_wr && BUS_REQ.wdata[`OFM_EN_BIT] && BUS_REQ.wdata[`OFM_GON_BIT];

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      ctl_reg <= ofm_ctl_t'(9'(`OFM_CTL5_RST));
    else if (ctl_wr)
    begin
      ctl_reg.en <= BUS_REQ.wdata[`OFM_EN_BIT];
      ctl_reg.gon <= BUS_REQ.wdata[`OFM_GON_BIT];
      ctl_reg.nom <= BUS_REQ.wdata[`OFM_NOM_BIT];
      ctl_reg.trim <= BUS_REQ.wdata[`OFM_TRIM_MSB:`OFM_TRIM_LSB];
      ctl_reg.step_src <= ofm_src_t'(BUS_REQ.wdata[`OFM_SRC_MSB:`OFM_SRC_LSB]);
    end
  end

  // Trim passes straight through: code 0 is slowest, all ones fastest
  assign OSC_TRIM = ctl_reg.trim;
  assign OSC_NOM_SEL = ctl_reg.nom;
  assign OSC_RANGE_4MHZ = ~ctl_reg.nom;
  assign OSC_ENABLE = ctl_reg.en;

  ////////////////////////////////////////////////////////////////////////////
  // Measurement sequencer

  ofm_meas_t state_reg;
  ofm_meas_t state_next;
  logic [2:0] win_reg;
  logic [2:0] per_reg;
  logic [`OFM_CNT_W-1:0] cnt_reg;
  logic win_end;

  // Window latched at arming so a later write cannot stretch it
  assign win_end = (state_reg == MS_COUNT) && aux_rise && (3'(per_reg + 3'h1) == win_reg);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      MS_IDLE: state_next = MS_IDLE;
      MS_ARMED:
        if (aux_rise)
          state_next = MS_COUNT;
      MS_COUNT:
        if (win_end)
          state_next = MS_DONE;
      MS_DONE: state_next = MS_DONE;
    endcase
    if (arm_req)
      state_next = MS_ARMED;
    else if (ctl_wr && !BUS_REQ.wdata[`OFM_EN_BIT])
      state_next = MS_IDLE;
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      state_reg <= MS_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      win_reg <= `OFM_WIN_NOM0;
    else if (arm_req)
      win_reg <= BUS_REQ.wdata[`OFM_NOM_BIT] ? `OFM_WIN_NOM1 : `OFM_WIN_NOM0;
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      per_reg <= 3'h0;
    else if (arm_req)
      per_reg <= 3'h0;
    else if ((state_reg == MS_COUNT) && aux_rise)
      per_reg <= 3'(per_reg + 3'h1);
  end

  // Saturates rather than wraps, so a far-off trim never looks close
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      cnt_reg <= '0;
    else if (arm_req)
      cnt_reg <= '0;
    else if ((state_reg == MS_COUNT) && osc_rise && !win_end && (cnt_reg != `OFM_CNT_MAX))
      cnt_reg <= cnt_reg + 8'h01;
  end

  assign MEAS_BUSY = (state_reg == MS_ARMED) || (state_reg == MS_COUNT);
  assign MEAS_DONE = (state_reg == MS_DONE);

  ////////////////////////////////////////////////////////////////////////////
  // Timing ticks

  logic sample_tick_reg;
  logic step_tick_reg;
  logic step_sel;

  always_comb
  begin
    unique case (ctl_reg.step_src)
      SRC_SUB: step_sel = sub_rise;
      SRC_OSC: step_sel = osc_rise;
      default: step_sel = aux_rise;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sample_tick_reg <= 1'b0;
      step_tick_reg <= 1'b0;
    end
    else
    begin
      sample_tick_reg <= aux_rise;
      step_tick_reg <= step_sel;
    end
  end

  assign SAMPLE_TICK = sample_tick_reg;
  assign STEP_TICK = step_tick_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  always_comb
  begin
    rdata_next = 16'h0000;
    if (BUS_REQ.rd)
    begin
      unique case (BUS_REQ.addr)
        // Struct packing differs from the bus map, so fields are placed by hand
        `OFM_CTL5_OFS:
          rdata_next = {6'h00, ctl_reg.step_src, ctl_reg.trim, 1'b0,
                        ctl_reg.nom, ctl_reg.gon, ctl_reg.en};
        `OFM_CNT_OFS: rdata_next = {8'h00, MEAS_BUSY ? `OFM_BUSY_VAL : cnt_reg};
        `OFM_STAT_OFS:
        begin
          rdata_next[`OFM_BUSY_BIT] = MEAS_BUSY;
          rdata_next[`OFM_DONE_BIT] = MEAS_DONE;
        end
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      rdata_reg <= 16'h0000;
    else
      rdata_reg <= rdata_next;
  end

  assign BUS_RDATA = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);

  arm_clears_count_a: assert property (
    arm_req |=> (cnt_reg == 8'h00) && (state_reg == MS_ARMED))
    else $error("Arming did not clear the counter");

  busy_read_value_a: assert property (
    cnt_rd && MEAS_BUSY |=> BUS_RDATA == 16'h0001)
    else $error("Counter read while busy was not 0x01");

  start_on_edge_a: assert property (
    (state_reg == MS_ARMED) && !aux_rise && !ctl_wr |=> state_reg == MS_ARMED)
    else $error("Counting began without a reference edge");

  count_step_a: assert property (
    (state_reg == MS_COUNT) && osc_rise && !win_end && !ctl_wr && (cnt_reg != 8'hff)
    |=> cnt_reg == $past(cnt_reg) + 8'h01)
    else $error("Oscillator edge not counted");

  window_length_a: assert property (
    $rose(MEAS_DONE) |-> $past(per_reg) == (win_reg - 3'h1))
    else $error("Window length does not match nominal select");

  result_hold_a: assert property (
    MEAS_DONE && !ctl_wr |=> MEAS_DONE && $stable(cnt_reg))
    else $error("Final count not held");

  nom_map_a: assert property (
    ctl_wr |=> (OSC_NOM_SEL == $past(BUS_REQ.wdata[2])) && (OSC_RANGE_4MHZ != OSC_NOM_SEL))
    else $error("Nominal select mapping wrong");

  trim_follow_a: assert property (
    ctl_wr |=> OSC_TRIM == $past(BUS_REQ.wdata[7:4]))
    else $error("Trim code not applied");

  sample_tick_a: assert property (
    aux_rise |=> SAMPLE_TICK ##1 !SAMPLE_TICK)
    else $error("Sample tick not one cycle after reference edge");

  step_osc_a: assert property (
    (ctl_reg.step_src == SRC_OSC) && osc_rise |=> STEP_TICK)
    else $error("Step tick missed oscillator edge");

  step_aux_a: assert property (
    (ctl_reg.step_src == SRC_AUX) && aux_rise
    |=> STEP_TICK)
    else $error("Step tick missed reference edge");

  step_sub_a: assert property (
    (ctl_reg.step_src == SRC_SUB) && sub_rise
    |=> STEP_TICK)
    else $error("Step tick missed subsystem edge");

  enable_follow_a: assert property (
    ctl_wr
    |=> OSC_ENABLE == $past(BUS_REQ.wdata[0]))
    else $error("Oscillator enable not applied");

  // Bus stays quiet between reads so a stale word is never taken
  rdata_quiet_a: assert property (
    !BUS_REQ.rd
    |=> BUS_RDATA == 16'h0000)
    else $error("Read data not zero without a read");

  abort_idle_a: assert property (
    ctl_wr && !BUS_REQ.wdata[0]
    |=> state_reg == MS_IDLE)
    else $error("Disable write did not abort");

  count_sat_a: assert property (
    (cnt_reg == 8'hff) && !arm_req
    |=> cnt_reg == 8'hff)
    else $error("Counter wrapped past full scale");

  done_read_a: assert property (
    cnt_rd && MEAS_DONE
    |=> BUS_RDATA[7:0] == $past(cnt_reg))
    else $error("Final count not returned on read");

  idle_hold_a: assert property (
    (state_reg == MS_IDLE) && !ctl_wr
    |=> $stable(cnt_reg))
    else $error("Counter moved while idle");

  saturate_c: cover property (cnt_reg == 8'hff);
  done_nom0_c: cover property (arm_req && !BUS_REQ.wdata[2] ##[1:200] MEAS_DONE);
  done_nom1_c: cover property (arm_req && BUS_REQ.wdata[2] ##[1:400] MEAS_DONE);
  busy_read_c: cover property ((state_reg == MS_COUNT) && cnt_rd);
  abort_c: cover property (MEAS_BUSY ##1 (state_reg == MS_IDLE));

endmodule

// ===== inc/ofm_pkg.sv
package ofm_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ofm_bus_req_t;

  typedef enum logic [1:0] {SRC_AUX, SRC_SUB, SRC_OSC, SRC_RSV} ofm_src_t;

  typedef struct packed {
    ofm_src_t step_src;
    logic [3:0] trim;
    logic nom;
    logic gon;
    logic en;
  } ofm_ctl_t;

  typedef enum logic [1:0] {MS_IDLE, MS_ARMED, MS_COUNT, MS_DONE} ofm_meas_t;

endpackage

// ===== inc/ofm_regs.svh
`ifndef OFM_REGS_SVH
`define OFM_REGS_SVH

// Register map, word offsets on the plain register port
`define OFM_ADDR_W 4
`define OFM_DATA_W 16
`define OFM_CTL5_OFS 4'h0
`define OFM_CNT_OFS 4'h1
`define OFM_STAT_OFS 4'h2

// Control register fields
`define OFM_EN_BIT 0
`define OFM_GON_BIT 1
`define OFM_NOM_BIT 2
`define OFM_TRIM_LSB 4
`define OFM_TRIM_MSB 7
`define OFM_SRC_LSB 8
`define OFM_SRC_MSB 9
`define OFM_CTL5_RST 16'h0000

// Status register fields
`define OFM_BUSY_BIT 0
`define OFM_DONE_BIT 1

// Counter values and window lengths in reference periods
`define OFM_CNT_W 8
`define OFM_BUSY_VAL 8'h01
`define OFM_CNT_MAX 8'hff
`define OFM_WIN_NOM0 3'h1
`define OFM_WIN_NOM1 3'h4

`endif
